// *** include/cutoff_pkg.sv ***
package cutoff_pkg;

    // Default rate of sys_clk in Hz.
    localparam int CLK_HZ = 10000000;
    // Time figures, each in its printed unit, then the counter widths.
    localparam int DROP_MS = 1;
    localparam int GAP_MS = 10;
    localparam int SKEW_MS = 120;
    localparam int SKEW_MAX_MS = 240;
    localparam int BLOCK_MS = 50;
    localparam int OFF_S = 2;
    localparam int CNT_W = 24;
    localparam int TRAIN_W = 4;
    // Short drop-outs tolerated back to back before cutoff.
    localparam logic [TRAIN_W-1:0] TRAIN_LIMIT = 4'h3;

    typedef enum logic [1:0] {
        ST_CUTOFF = 2'b00,
        ST_STANDBY = 2'b01,
        ST_FAULT = 2'b10
    } mon_state_type;

endpackage

// *** hdl/cutoff_channel.sv ***
`timescale 1ns/1ns
// One input channel: synchroniser, test-pulse filter, drop-out train check.
module cutoff_channel
    import cutoff_pkg::*;
#(
    parameter logic [CNT_W-1:0] DROP_CYC = 24'h1,
    parameter logic [CNT_W-1:0] GAP_CYC = 24'h1
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic pos,
    input wire logic neg,
    output logic powered,
    output logic demand,
    output logic sensed
);

    typedef struct packed {
        logic [1:0] sync;
        logic [CNT_W-1:0] low_cnt;
        logic [CNT_W-1:0] gap_cnt;
        logic [TRAIN_W-1:0] train;
        logic demand;
    } chan_state_type;

    chan_state_type s_q;
    chan_state_type s_d;
    logic raw_ok;

    // Reversed polarity or a missing voltage both read as unpowered.
    assign raw_ok = pos & ~neg;

    always_comb begin
        s_d = s_q;
        s_d.sync = {s_q.sync[0], raw_ok};
        if (!s_q.sync[1]) begin
            if (s_q.low_cnt != DROP_CYC) begin
                s_d.low_cnt = s_q.low_cnt + 24'h1;
            end
            if (s_q.low_cnt == DROP_CYC) begin
                s_d.demand = 1'b1;
            end
            if (s_q.low_cnt == '0) begin
                if (s_q.gap_cnt != GAP_CYC) begin
                    s_d.train = s_q.train + 4'h1;
                end else begin
                    s_d.train = '0;
                end
            end
            s_d.gap_cnt = '0;
        end else begin
            s_d.low_cnt = '0;
            if (s_q.gap_cnt != GAP_CYC) begin
                s_d.gap_cnt = s_q.gap_cnt + 24'h1;
            end
            if (s_q.train > TRAIN_LIMIT) begin
                s_d.demand = 1'b1;
                s_d.train = '0;
            end else if (s_q.gap_cnt == GAP_CYC) begin
                s_d.demand = 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s_q <= '{sync: 2'h0, low_cnt: '0, gap_cnt: '0, train: '0,
                     demand: 1'b1};
        end else begin
            s_q <= s_d;
        end
    end

    assign powered = ~s_q.demand;
    assign demand = s_q.demand;
    assign sensed = s_q.sync[1];

endmodule

// *** hdl/torque_cutoff_monitor.sv ***
`timescale 1ns/1ns
module torque_cutoff_monitor
    import cutoff_pkg::*;
#(
    parameter int CLK_FREQ_HZ = CLK_HZ,
    parameter int GATE_W = 6,
    parameter logic [CNT_W-1:0] SKEW_CYC =
        CNT_W'((longint'(CLK_FREQ_HZ) * (SKEW_MS + SKEW_MAX_MS) / 2) / 1000),
    parameter logic [CNT_W-1:0] BOOT_CYC =
        CNT_W'(longint'(CLK_FREQ_HZ) * BLOCK_MS / 1000)
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic cutoff_ch1_pos,
    input wire logic cutoff_ch1_neg,
    input wire logic cutoff_ch2_pos,
    input wire logic cutoff_ch2_neg,
    input wire logic gate_supply_ok,
    input wire logic drive_enabled,
    input wire logic error_clear,
    input wire logic motion_cmd,
    input wire logic [GATE_W-1:0] pwm_in,
    output logic [GATE_W-1:0] pwm_out,
    output logic fault_relay_a,
    output logic fault_relay_b,
    output logic torque_cutoff,
    output logic drive_error,
    output logic fault_latched,
    output logic ch1_sensed,
    output logic ch2_sensed,
    output logic ch1_demand,
    output logic ch2_demand,
    output logic motion_run
);

    // Filter limits: drop-outs strictly over 1 ms trip, a gap of 10 ms
    // rearms the filter.
    localparam logic [CNT_W-1:0] DROP_CYC =
        CNT_W'(longint'(CLK_FREQ_HZ) * DROP_MS / 1000 + 1);
    localparam logic [CNT_W-1:0] GAP_CYC =
        CNT_W'(longint'(CLK_FREQ_HZ) * GAP_MS / 1000);

    typedef struct packed {
        mon_state_type st;
        logic [CNT_W-1:0] skew_cnt;
        logic [CNT_W-1:0] boot_cnt;
        logic booted;
        logic err;
        logic fault;
        logic run;
        logic [GATE_W-1:0] pwm;
        logic [1:0] en_sync;
        logic [1:0] clr_sync;
        logic [1:0] sup_sync;
        logic [1:0] mot_sync;
        logic mot_prev;
    } mon_reg_type;

    mon_reg_type s_q;
    mon_reg_type s_d;
    logic c1_dem;
    logic c2_dem;
    logic c1_sen;
    logic c2_sen;
    logic c1_pow;
    logic c2_pow;
    logic any_dem;
    logic mismatch;

    cutoff_channel #(
        .DROP_CYC(DROP_CYC),
        .GAP_CYC(GAP_CYC)
    ) u_ch1 (
        .sys_clk(sys_clk),
        .rst(rst),
        .pos(cutoff_ch1_pos),
        .neg(cutoff_ch1_neg),
        .powered(c1_pow),
        .demand(c1_dem),
        .sensed(c1_sen)
    );

    cutoff_channel #(
        .DROP_CYC(DROP_CYC),
        .GAP_CYC(GAP_CYC)
    ) u_ch2 (
        .sys_clk(sys_clk),
        .rst(rst),
        .pos(cutoff_ch2_pos),
        .neg(cutoff_ch2_neg),
        .powered(c2_pow),
        .demand(c2_dem),
        .sensed(c2_sen)
    );

    assign any_dem = c1_dem | c2_dem;
    assign mismatch = c1_pow ^ c2_pow;

    always_comb begin
        s_d = s_q;
        s_d.en_sync = {s_q.en_sync[0], drive_enabled};
        s_d.clr_sync = {s_q.clr_sync[0], error_clear};
        s_d.sup_sync = {s_q.sup_sync[0], gate_supply_ok};
        s_d.mot_sync = {s_q.mot_sync[0], motion_cmd};

        // Disagreement timer; the midpoint of 120 and 240 ms trips it.
        if (mismatch) begin
            if (s_q.skew_cnt != SKEW_CYC) begin
                s_d.skew_cnt = s_q.skew_cnt + 24'h1;
            end
        end else begin
            s_d.skew_cnt = '0;
        end

        // Start-up window; cutoff is held until boot_cnt reaches BOOT_CYC.
        if (!s_q.booted) begin
            s_d.boot_cnt = s_q.boot_cnt + 24'h1;
            if (s_q.boot_cnt == BOOT_CYC) begin
                s_d.booted = 1'b1;
            end
        end

        // Fault latch; only reset, i.e. a power cycle, clears it.
        if ((mismatch && s_q.skew_cnt == SKEW_CYC) || !s_q.sup_sync[1]) begin
            s_d.fault = 1'b1;
        end

        // A clear is taken once the drive is disabled, or once both inputs
        // are repowered with the drive still enabled.
        if (s_q.clr_sync[1] && (!any_dem || !s_q.en_sync[1])) begin
            s_d.err = 1'b0;
        end

        case (s_q.st)
            ST_STANDBY: begin
                if (s_d.fault) begin
                    s_d.st = ST_FAULT;
                end else if (any_dem) begin
                    s_d.st = ST_CUTOFF;
                    if (s_q.en_sync[1]) begin
                        s_d.err = 1'b1;
                    end
                end
            end
            ST_CUTOFF: begin
                if (s_d.fault) begin
                    s_d.st = ST_FAULT;
                end else if (!any_dem && !s_q.err && s_q.booted) begin
                    s_d.st = ST_STANDBY;
                end
            end
            ST_FAULT: begin
                s_d.st = ST_FAULT;
            end
            default: begin
                s_d.st = ST_FAULT;
            end
        endcase

        // Motion resumes only on a fresh command after leaving cutoff; a
        // command held through the cutoff does not restart the motor.
        s_d.mot_prev = s_q.mot_sync[1];
        if (s_q.st != ST_STANDBY) begin
            s_d.run = 1'b0;
        end else if (s_q.mot_sync[1] && !s_q.mot_prev) begin
            s_d.run = 1'b1;
        end
        if (!s_q.mot_sync[1]) begin
            s_d.run = 1'b0;
        end

        // Gates are forced low whenever not in standby.
        if (s_d.st == ST_STANDBY) begin
            s_d.pwm = pwm_in;
        end else begin
            s_d.pwm = '0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s_q.st <= ST_CUTOFF;
            s_q.skew_cnt <= '0;
            s_q.boot_cnt <= '0;
            s_q.booted <= 1'b0;
            s_q.err <= 1'b0;
            s_q.fault <= 1'b0;
            s_q.run <= 1'b0;
            s_q.pwm <= '0;
            s_q.en_sync <= 2'h0;
            s_q.clr_sync <= 2'h0;
            s_q.sup_sync <= 2'h3;
            s_q.mot_sync <= 2'h0;
            s_q.mot_prev <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    assign pwm_out = s_q.pwm;
    // Relay closed (high on both contacts) while healthy.
    assign fault_relay_a = ~s_q.fault;
    assign fault_relay_b = ~s_q.fault;
    assign torque_cutoff = (s_q.st != ST_STANDBY);
    assign drive_error = s_q.err;
    assign fault_latched = s_q.fault;
    assign ch1_sensed = c1_sen;
    assign ch2_sensed = c2_sen;
    assign ch1_demand = c1_dem;
    assign ch2_demand = c2_dem;
    assign motion_run = s_q.run;

endmodule

// *** tb/cutoff_asserts.sv ***
`timescale 1ns/1ns
module cutoff_asserts
    import cutoff_pkg::*;
#(
    parameter int GATE_W = 6
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic cutoff_ch1_pos,
    input wire logic cutoff_ch1_neg,
    input wire logic [GATE_W-1:0] pwm_in,
    input wire logic [GATE_W-1:0] pwm_out,
    input wire logic fault_relay_a,
    input wire logic fault_relay_b,
    input wire logic torque_cutoff,
    input wire logic drive_error,
    input wire logic fault_latched,
    input wire logic ch1_sensed,
    input wire logic ch1_demand,
    input wire logic ch2_demand
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    // Cutoff must be reached within 50 ms at 10 kHz test clock.
    sequence s_cut_arrive;
        ##[0:500] torque_cutoff;
    endsequence

    property p_gate_off;
        torque_cutoff |-> pwm_out == '0;
    endproperty
    property p_pass;
        !torque_cutoff && !$past(torque_cutoff) |-> pwm_out == $past(pwm_in);
    endproperty
    property p_relay_open;
        fault_latched |=> !fault_relay_a && !fault_relay_b;
    endproperty
    property p_relay_closed;
        !fault_latched |-> fault_relay_a && fault_relay_b;
    endproperty
    property p_fault_hold;
        fault_latched |=> fault_latched;
    endproperty
    property p_fault_cut;
        fault_latched |-> s_cut_arrive;
    endproperty
    property p_demand_cut;
        ch1_demand || ch2_demand |-> s_cut_arrive;
    endproperty
    property p_clear;
        !torque_cutoff |-> !drive_error && !fault_latched
            && !$past(ch1_demand) && !$past(ch2_demand);
    endproperty
    property p_sensed;
        !$past(rst) && !$past(rst, 2) |-> ch1_sensed ==
            ($past(cutoff_ch1_pos, 2) && !$past(cutoff_ch1_neg, 2));
    endproperty
    property p_error;
        $rose(drive_error) |-> torque_cutoff;
    endproperty

    a_gate_off: assert property (p_gate_off)
        else $error("gates live in cutoff");
    a_pass: assert property (p_pass)
        else $error("gates not passed in standby");
    a_relay_open: assert property (p_relay_open)
        else $error("relay closed on fault");
    a_relay_closed: assert property (p_relay_closed)
        else $error("relay open without fault");
    a_fault_hold: assert property (p_fault_hold)
        else $error("fault released");
    a_fault_cut: assert property (p_fault_cut)
        else $error("fault without cutoff");
    a_demand_cut: assert property (p_demand_cut)
        else $error("demand without cutoff");
    a_clear: assert property (p_clear)
        else $error("standby with pending cause");
    a_sensed: assert property (p_sensed)
        else $error("sensed level wrong");
    a_error: assert property (p_error)
        else $error("error outside cutoff");
endmodule

bind torque_cutoff_monitor cutoff_asserts #(.GATE_W(GATE_W)) chk (
    .sys_clk(sys_clk), .rst(rst), .cutoff_ch1_pos(cutoff_ch1_pos),
    .cutoff_ch1_neg(cutoff_ch1_neg), .pwm_in(pwm_in), .pwm_out(pwm_out),
    .fault_relay_a(fault_relay_a), .fault_relay_b(fault_relay_b),
    .torque_cutoff(torque_cutoff), .drive_error(drive_error),
    .fault_latched(fault_latched), .ch1_sensed(ch1_sensed),
    .ch1_demand(ch1_demand), .ch2_demand(ch2_demand)
);

// *** tb/relay_source.sv ***
`timescale 1ns/1ns
// Safety relay outputs; an unpowered channel drives both wires low.
module relay_source (
    input wire logic ch1_on,
    input wire logic ch2_on,
    input wire logic ch1_rev,
    output logic ch1_pos,
    output logic ch1_neg,
    output logic ch2_pos,
    output logic ch2_neg
);
    assign ch1_pos = ch1_on && !ch1_rev;
    assign ch1_neg = ch1_on && ch1_rev;
    assign ch2_pos = ch2_on;
    assign ch2_neg = 1'b0;
endmodule

// *** tb/testbench.sv ***
`timescale 1ns/1ns
module testbench
    import cutoff_pkg::*;
;
    logic sys_clk, rst = 1, ch1_on = 0, ch2_on = 0, ch1_rev = 0;
    logic gate_ok = 1, en = 0, clr = 0, mcmd = 0;
    logic [5:0] pwm_in = 6'h2d;
    logic [5:0] pwm_out;
    logic p1, n1, p2, n2, relay_a, relay_b, torque_cutoff, drive_error;
    logic fault_latched, motion_run, s1, s2;
    int fail_count = 0;
    int checked = 0;

    relay_source src (.ch1_on(ch1_on), .ch2_on(ch2_on), .ch1_rev(ch1_rev),
        .ch1_pos(p1), .ch1_neg(n1), .ch2_pos(p2), .ch2_neg(n2));
    torque_cutoff_monitor #(.CLK_FREQ_HZ(10000)) uut (.sys_clk(sys_clk),
        .rst(rst), .cutoff_ch1_pos(p1), .cutoff_ch1_neg(n1),
        .cutoff_ch2_pos(p2), .cutoff_ch2_neg(n2), .gate_supply_ok(gate_ok),
        .drive_enabled(en), .error_clear(clr), .motion_cmd(mcmd),
        .pwm_in(pwm_in), .pwm_out(pwm_out), .fault_relay_a(relay_a),
        .fault_relay_b(relay_b), .torque_cutoff(torque_cutoff),
        .drive_error(drive_error), .fault_latched(fault_latched),
        .ch1_sensed(s1), .ch2_sensed(s2), .ch1_demand(), .ch2_demand(),
        .motion_run(motion_run));

    initial begin
        sys_clk = 0;
        forever #50 sys_clk = ~sys_clk;
    end

    task end_of_test();
        $display("checks %0d errors %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task tick(input int n);
        repeat (n) @(posedge sys_clk);
        #10;
    endtask

    task check(input logic ok, input string msg);
        checked++;
        if (ok !== 1'b1) begin
            fail_count++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask

    // Waits on torque_cutoff, or on fault_latched when which is 1.
    task wait_for(input int which, input logic v, input int n);
        for (int i = 0; i < n; i++) begin
            if ((which ? fault_latched : torque_cutoff) !== v) tick(1);
        end
        check((which ? fault_latched : torque_cutoff) === v, "wait ran out");
        if (fail_count > 0) end_of_test();
    endtask

    task drop1(input int lo, input int gap);
        ch1_on = 0;
        tick(lo);
        ch1_on = 1;
        tick(gap);
    endtask

    initial begin
        tick(8);
        rst = 0;
        check(torque_cutoff && relay_a && relay_b && !drive_error, "reset");
        ch1_on = 1;
        ch2_on = 1;
        wait_for(0, 0, 700);
        tick(2);
        check(pwm_out === pwm_in, "gates");
        repeat (4) drop1(10, 100);
        check(torque_cutoff === 0, "test pulse");
        repeat (6) drop1(8, 30);
        wait_for(0, 1, 500);
        wait_for(0, 0, 300);
        ch1_on = 0;
        ch2_on = 0;
        wait_for(0, 1, 500);
        check(!s1 && !s2, "sensed low");
        ch1_on = 1;
        ch2_on = 1;
        wait_for(0, 0, 200);
        check(!drive_error && !fault_latched, "no error");
        en = 1;
        mcmd = 1;
        tick(5);
        ch1_on = 0;
        ch2_on = 0;
        wait_for(0, 1, 500);
        tick(3);
        check(drive_error === 1, "error");
        ch1_on = 1;
        ch2_on = 1;
        tick(300);
        check(torque_cutoff === 1, "error blocks");
        clr = 1;
        wait_for(0, 0, 100);
        clr = 0;
        tick(3);
        check(!drive_error && motion_run === 0, "resume");
        mcmd = 0;
        tick(5);
        mcmd = 1;
        tick(5);
        check(motion_run === 1, "rerun");
        ch1_on = 0;
        ch2_on = 0;
        wait_for(0, 1, 500);
        en = 0;
        clr = 1;
        tick(5);
        clr = 0;
        check(drive_error === 0, "clear while off");
        ch1_on = 1;
        ch2_on = 1;
        wait_for(0, 0, 200);
        ch1_rev = 1;
        tick(1100);
        check(fault_latched === 0, "early fault");
        check(!s1 && s2, "sensed skew");
        wait_for(1, 1, 1300);
        tick(2);
        check(torque_cutoff && !relay_a && !relay_b, "fault");
        ch1_rev = 0;
        tick(300);
        check(fault_latched && torque_cutoff, "latched");
        ch1_rev = 1;
        rst = 1;
        tick(2);
        rst = 0;
        check(fault_latched === 0, "power cycle");
        wait_for(1, 1, 2500);
        ch1_rev = 0;
        rst = 1;
        tick(2);
        rst = 0;
        wait_for(0, 0, 700);
        gate_ok = 0;
        wait_for(1, 1, 50);
        wait_for(0, 1, 500);
        end_of_test();
    end
endmodule
